// file: verilog/flash_host_pkg.sv
// constants for the parallel flash command and protection host controller
package flash_host_pkg;
   // unlock and command codes
   localparam logic [7:0] unlock_data1 = 8'hAA;
   localparam logic [7:0] unlock_data2 = 8'h55;
   localparam logic [7:0] cmd_reset    = 8'hF0;
   localparam logic [7:0] cmd_sig      = 8'h90;
   localparam logic [7:0] cmd_program  = 8'hA0;
   localparam logic [7:0] cmd_erase_su = 8'h80;
   localparam logic [7:0] cmd_chip_ers = 8'h10;
   localparam logic [7:0] cmd_blk_ers  = 8'h30;
   localparam logic [7:0] cmd_suspend  = 8'hB0;
   localparam logic [7:0] cmd_resume   = 8'h30;
   // coded cycle addresses, word and byte mode
   localparam logic [17:0] word_addr1 = 18'h0_5555;
   localparam logic [17:0] word_addr2 = 18'h0_2AAA;
   localparam logic [17:0] byte_addr1 = 18'h0_AAAA;
   localparam logic [17:0] byte_addr2 = 18'h0_5555;
   // field positions
   localparam int blk_lsb = 12;
   localparam int blk_w   = 6;
   localparam int a_bit0  = 0;
   localparam int a_bit1  = 1;
   localparam int a_bit6  = 6;
   localparam int a_bit12 = 12;
   localparam int a_bit15 = 15;
   localparam logic [7:0] prot_yes = 8'h01;
   // timing
   localparam int clk_mhz      = 200;
   localparam int protect_us   = 100;
   localparam int unprotect_ms = 10;
   localparam int protect_cyc   = protect_us * clk_mhz;
   localparam int unprotect_cyc = unprotect_ms * 1000 * clk_mhz;
   localparam int strobe_cyc    = 8;
   // operations requested by the user side
   localparam logic [3:0] op_reset     = 4'h0;
   localparam logic [3:0] op_read      = 4'h1;
   localparam logic [3:0] op_sig_read  = 4'h2;
   localparam logic [3:0] op_program   = 4'h3;
   localparam logic [3:0] op_blk_erase = 4'h4;
   localparam logic [3:0] op_chip_ers  = 4'h5;
   localparam logic [3:0] op_suspend   = 4'h6;
   localparam logic [3:0] op_resume    = 4'h7;
   localparam logic [3:0] op_protect   = 4'h8;
   localparam logic [3:0] op_unprotect = 4'h9;
   localparam logic [3:0] op_prot_ver  = 4'hA;
   localparam logic [3:0] op_unp_ver   = 4'hB;
endpackage

// file: verilog/flash_host.sv
// host controller driving a parallel flash through its pins
// Operation
// R1 - signature read at A1 high gives status
// R2 - protect raises A9 and oe to high voltage
// R3 - write enable low 100 us to protect
// R4 - protection verify returns 01h when protected
// R5 - device ignores writes to protected blocks
// R6 - high voltage reset pin unprotects temporarily
// R7 - normal reset level restores protection
// R8 - protect every block before full unprotect
// R9 - unprotect pulse with high voltages lasts 10 ms
// R10 - verify each block separately, 00h unprotected
// R11 - instructions span one to six cycles
// R12 - issue command cycles in exact order
// R13 - unlock pair AAh 55h precedes commands
// R14 - F0h returns device to read array
// R15 - 90h after unlock gives signature reads
// R16 - program uses four cycles ending address data
// R17 - device keeps one protection flag per block
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
   parameter int protect_cycles   = flash_host_pkg::protect_cyc,
   parameter int unprotect_cycles = flash_host_pkg::unprotect_cyc,
   parameter int nblocks          = 64
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   // user side
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [3:0]  req_op,
   input  wire logic [17:0] req_addr,
   input  wire logic [15:0] req_data,
   input  wire logic        byte_mode,
   input  wire logic        temp_unprotect,
   output logic             done,
   output logic [15:0]      rd_data,
   output logic             verify_fail,
   // flash pins
   output logic [17:0]      addr,
   output logic [15:0]      dq_out,
   input  wire logic [15:0] dq_in,
   output logic             dq_oe_n,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic             a9_high_volt,
   output logic             oe_high_volt,
   output logic             ce_high_volt,
   output logic             reset_unprotect_pin_high_volt,
   output logic             byte_n
);
   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_setup = 3'b001,
      st_low   = 3'b010,
      st_high  = 3'b011,
      st_read  = 3'b100,
      st_done  = 3'b101
   } state_e;

   state_e      state;
   state_e      next_state;
   logic [2:0]  cyc;
   logic [2:0]  ncyc;
   logic [3:0]  op;
   logic [17:0] op_addr;
   logic [15:0] op_data;
   logic [31:0] timer;
   logic [31:0] low_len;
   logic [nblocks-1:0] prot_done;   // blocks protected by this controller since reset or the last finished full unprotect

   // one command cycle slot: address and data for cycle index
   logic [17:0] slot_addr;
   logic [7:0]  slot_data;
   wire  [17:0] ua1 = byte_mode ? flash_host_pkg::byte_addr1 : flash_host_pkg::word_addr1;
   wire  [17:0] ua2 = byte_mode ? flash_host_pkg::byte_addr2 : flash_host_pkg::word_addr2;
   wire         single = (op == flash_host_pkg::op_suspend) || (op == flash_host_pkg::op_resume);
   wire         hv_op  = (op == flash_host_pkg::op_protect) || (op == flash_host_pkg::op_unprotect);
   wire         ver_op = (op == flash_host_pkg::op_prot_ver) || (op == flash_host_pkg::op_unp_ver)
                         || (op == flash_host_pkg::op_read);
   wire [7:0]   third = (op == flash_host_pkg::op_sig_read) ? flash_host_pkg::cmd_sig :
                        (op == flash_host_pkg::op_program)  ? flash_host_pkg::cmd_program :
                        (op == flash_host_pkg::op_reset)    ? flash_host_pkg::cmd_reset :
                        flash_host_pkg::cmd_erase_su;
   // the next cycle's slot loads while the strobe is still high
   wire [2:0]   slot_cyc = (state == st_high) ? cyc + 3'd1 : cyc;
   // full unprotect only once every block was protected here; a reset forgets that record
   wire [flash_host_pkg::blk_w-1:0] blk_idx = op_addr[flash_host_pkg::blk_lsb +: flash_host_pkg::blk_w];
   wire         all_prot       = &prot_done;
   wire         unprot_refused = (op == flash_host_pkg::op_unprotect) && !all_prot; // [R8]

   // cycle table, unlock pair first except for suspend and resume, and again before erase confirm
   always_comb
   begin
      slot_addr = ua1;
      slot_data = flash_host_pkg::unlock_data1;
      if (single)
      begin
         slot_addr = op_addr;                                              // [R11]
         slot_data = (op == flash_host_pkg::op_suspend) ? flash_host_pkg::cmd_suspend
                                                        : flash_host_pkg::cmd_resume;
      end
      else
      begin
         case (slot_cyc)
            3'd0: slot_data = flash_host_pkg::unlock_data1;                // [R13]
            3'd1:
            begin
               slot_addr = ua2;
               slot_data = flash_host_pkg::unlock_data2;                   // [R13]
            end
            3'd2: slot_data = third;                                       // [R14] [R15]
            3'd3:
            begin
               slot_addr = (op == flash_host_pkg::op_program) ? op_addr : ua1;
               slot_data = (op == flash_host_pkg::op_program) ? op_data[7:0]
                                                               : flash_host_pkg::unlock_data1; // [R16]
            end
            3'd4:
            begin
               slot_addr = ua2;
               slot_data = flash_host_pkg::unlock_data2;                   // [R13]
            end
            default:
            begin
               slot_addr = (op == flash_host_pkg::op_blk_erase) ? op_addr : ua1;
               slot_data = (op == flash_host_pkg::op_blk_erase) ? flash_host_pkg::cmd_blk_ers
                                                                 : flash_host_pkg::cmd_chip_ers;
            end
         endcase
      end
   end

   // cycle counts per instruction: 1, 3, 4 or 6
   always_comb
   begin
      if (single)
         ncyc = 3'd1;                                                      // [R11]
      else if (op == flash_host_pkg::op_program)
         ncyc = 3'd4;                                                      // [R16]
      else if ((op == flash_host_pkg::op_blk_erase) || (op == flash_host_pkg::op_chip_ers))
         ncyc = 3'd6;
      else
         ncyc = 3'd3;
   end

   assign req_ready = (state == st_idle);
   wire last_cyc  = (cyc == ncyc - 3'd1);
   wire timer_end = (timer >= low_len);
   wire sig_to_read = (state == st_high) && timer_end && last_cyc && (op == flash_host_pkg::op_sig_read);

   always_comb
   begin
      next_state = state;
      case (state)
         st_idle:  if (req_valid) next_state = st_setup;
         st_setup: next_state = ver_op ? st_read : unprot_refused ? st_done : st_low; // [R8]
         st_low:   if (timer_end) next_state = st_high;
         st_high:  if (timer_end) next_state = sig_to_read ? st_read
                                                : (hv_op || last_cyc) ? st_done : st_low; // [R12] [R15]
         st_read:  if (timer_end) next_state = st_done;
         default:  next_state = st_idle;
      endcase
   end

   // state, timer and cycle index
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state   <= st_idle;
         cyc     <= 3'd0;
         timer   <= 32'h0000_0000;
         op      <= flash_host_pkg::op_reset;
         op_addr <= 18'h0_0000;
         op_data <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         timer <= (next_state != state) ? 32'h0000_0000 : timer + 32'h0000_0001;
         if (state == st_idle && req_valid)
         begin
            op      <= req_op;
            op_addr <= req_addr;
            op_data <= req_data;
            cyc     <= 3'd0;
         end
         else if (state == st_high && timer_end)
            cyc <= cyc + 3'd1;
      end
   end

   // write pulse length: long for protect and unprotect
   always_comb
   begin
      if (op == flash_host_pkg::op_protect)
         low_len = 32'(protect_cycles);                                    // [R3]
      else if (op == flash_host_pkg::op_unprotect)
         low_len = 32'(unprotect_cycles);                                  // [R9]
      else
         low_len = 32'(flash_host_pkg::strobe_cyc);
   end

   // record of protected blocks, cleared by a finished full unprotect
   always_ff @(posedge clk)
   begin
      if (!nrst)
         prot_done <= '0;
      else if (state == st_done && op == flash_host_pkg::op_protect)
         prot_done[blk_idx] <= 1'b1;                                       // [R8]
      else if (state == st_done && op == flash_host_pkg::op_unprotect && all_prot)
         prot_done <= '0;
   end

   // pin drive, registered so the flash sees clean levels
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         addr <= 18'h0_0000;
         dq_out <= 16'h0000;
         dq_oe_n <= 1'b1;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         a9_high_volt <= 1'b0;
         oe_high_volt <= 1'b0;
         ce_high_volt <= 1'b0;
         done <= 1'b0;
         rd_data <= 16'h0000;
         verify_fail <= 1'b0;
      end
      else
      begin
         done <= (state == st_done);
         ce_n <= !(next_state == st_low || next_state == st_high || next_state == st_read); // low through every command cycle, strobe high or low, and the read
         we_n <= !(next_state == st_low);                                  // [R3]
         oe_n <= !(state == st_read) || (state == st_low && hv_op);
         dq_oe_n <= !(next_state == st_low || next_state == st_high) || hv_op; // data on as the strobe falls
         a9_high_volt <= (hv_op || op == flash_host_pkg::op_prot_ver
                          || op == flash_host_pkg::op_unp_ver) && state != st_idle; // [R2]
         oe_high_volt <= hv_op && state != st_idle;                        // [R2]
         ce_high_volt <= (op == flash_host_pkg::op_unprotect) && state != st_idle; // [R9]
         if (state == st_setup && hv_op)
         begin
            addr <= op_addr;
            if (op == flash_host_pkg::op_unprotect)
            begin
               addr[flash_host_pkg::a_bit12] <= 1'b1;                      // [R9]
               addr[flash_host_pkg::a_bit15] <= 1'b1;
            end
         end
         else if (state == st_setup && ver_op && op != flash_host_pkg::op_read)
         begin
            addr <= op_addr;                                               // [R10] block by its own address
            addr[flash_host_pkg::a_bit0] <= 1'b0;
            addr[flash_host_pkg::a_bit1] <= 1'b1;
            addr[flash_host_pkg::a_bit6] <= (op == flash_host_pkg::op_unp_ver);
         end
         else if ((state == st_setup && op == flash_host_pkg::op_read) || sig_to_read)
            addr <= op_addr;                                               // [R15]
         else if (!hv_op && (state == st_setup || (state == st_high && timer_end)))
         begin
            addr <= slot_addr;
            dq_out <= {8'h00, slot_data};
         end
         if (state == st_read && timer_end)
         begin
            rd_data <= dq_in;
            if (op == flash_host_pkg::op_prot_ver)
               verify_fail <= dq_in[7:0] != flash_host_pkg::prot_yes;     // [R4]
            else if (op == flash_host_pkg::op_unp_ver)
               verify_fail <= dq_in[7:0] != 8'h00;                         // [R10]
         end
         if (state == st_setup && unprot_refused)
            verify_fail <= 1'b1;                                           // [R8]
      end
   end

   assign reset_unprotect_pin_high_volt = temp_unprotect;                  // [R6] [R7]
   assign byte_n = !byte_mode;
endmodule
`default_nettype wire

// file: verification/flash_host_assertions.sv
// port checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_assertions #(
   parameter int protect_cycles = flash_host_pkg::protect_cyc
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        temp_unprotect,
   input wire logic        byte_mode,
   input wire logic        done,
   input wire logic [17:0] addr,
   input wire logic        dq_oe_n,
   input wire logic        ce_n,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic        a9_high_volt,
   input wire logic        oe_high_volt,
   input wire logic        ce_high_volt,
   input wire logic        reset_unprotect_pin_high_volt,
   input wire logic        byte_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [31:0] low_cnt;

   // length of the current write strobe, cleared on release
   always_ff @(posedge clk)
   begin
      low_cnt <= (!nrst || we_n) ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
   end

   a_reset_idle: assert property (disable iff (1'b0) !nrst |=> ce_n && oe_n && we_n && dq_oe_n && !done)
      else $error("pins not idle after reset");
   a_rp_follow: assert property (reset_unprotect_pin_high_volt == temp_unprotect)
      else $error("reset pin level differs from request");
   a_byte_pin: assert property (byte_n == !byte_mode)
      else $error("byte pin wrong");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_no_contend: assert property (!oe_n |-> dq_oe_n)
      else $error("data driven during read");
   a_write_drive: assert property (!we_n && !a9_high_volt |-> !dq_oe_n && !ce_n && oe_n)
      else $error("write cycle badly formed");
   a_oe_needs_a9: assert property (oe_high_volt |-> a9_high_volt)
      else $error("oe high voltage without a9");
   a_unprot_setup: assert property (ce_high_volt |-> a9_high_volt && oe_high_volt && addr[12] && addr[15])
      else $error("unprotect setup wrong");
   a_protect_len: assert property ($rose(we_n) && $past(nrst) && $past(oe_high_volt) && !$past(ce_high_volt)
      |-> low_cnt >= protect_cycles)
      else $error("protect pulse too short");
   c_protect: cover property ($rose(we_n) && $past(oe_high_volt));
   c_unprot: cover property (ce_high_volt);
   c_done: cover property (done);
endmodule
bind flash_host flash_host_assertions #(.protect_cycles(protect_cycles)) u_chk (.clk, .nrst, .temp_unprotect,
   .byte_mode, .done, .addr, .dq_oe_n, .ce_n, .oe_n, .we_n, .a9_high_volt, .oe_high_volt, .ce_high_volt,
   .reset_unprotect_pin_high_volt, .byte_n);
`default_nettype wire

// file: verification/flash_dev_model.sv
// behavioural flash device: command decode, per-block protection, sparse array
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int prot_min_ns = 100
) (
   input  wire logic [17:0] addr,
   input  wire logic [15:0] dq_out,
   output logic      [15:0] dq_in,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        a9_hv,
   input  wire logic        oe_hv,
   input  wire logic        ce_hv,
   input  wire logic        rp_hv,
   input  wire logic        byte_n
);
   logic [63:0] prot = '0; // one flag per block
   logic [7:0]  mem [int];
   logic [2:0]  step = 3'h0;
   logic        sig = 1'b0;
   logic [15:0] val;
   logic [15:0] last = 16'h0000;
   realtime     t_fall;
   wire  [5:0]  blk = addr[17:12];
   wire         ok = !prot[blk] || rp_hv;
   wire  [14:0] c1 = byte_n ? 15'h5555 : 15'h2AAA;
   wire  [14:0] c2 = byte_n ? 15'h2AAA : 15'h5555;
   wire  [7:0]  d = dq_out[7:0];

   // commands latch on the rising strobe; bad sequences fall back to array read
   always @(negedge we_n) t_fall = $realtime;
   always @(posedge we_n)
   begin
      if (a9_hv && oe_hv && ce_hv && &prot)
         prot = '0;
      else if (a9_hv && oe_hv && !ce_hv && !ce_n && $realtime - t_fall >= prot_min_ns)
         prot[blk] = 1'b1;
      else if (!ce_n && !a9_hv)
      begin
         sig = 1'b0;
         case (step)
            3'h0: step = (d == 8'hAA && addr[14:0] == c1) ? 3'h1 : 3'h0;
            3'h1: step = (d == 8'h55 && addr[14:0] == c2) ? 3'h2 : 3'h0;
            3'h2:
            begin
               sig = (d == 8'h90);
               step = (d == 8'hA0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
            end
            3'h3:
            begin
               if (ok) mem[addr] = (mem.exists(addr) ? mem[addr] : 8'hFF) & d;
               step = 3'h0;
            end
            3'h4: step = (d == 8'hAA) ? 3'h5 : 3'h0;
            3'h5: step = (d == 8'h55) ? 3'h6 : 3'h0;
            default:
            begin
               foreach (mem[k])
                  if ((d == 8'h10 || (d == 8'h30 && k[17:12] == blk)) && (!prot[k[17:12]] || rp_hv))
                     mem[k] = 8'hFF;
               step = 3'h0;
            end
         endcase
      end
   end

   // read path; a released bus shows the inverse of the last value
   always @(addr, ce_n, oe_n, we_n, a9_hv, sig, prot, step)
   begin
      if (a9_hv || (sig && addr[1] && !addr[0]))
         val = {15'h0000, prot[blk]};
      else
         val = {8'h00, mem.exists(addr) ? mem[addr] : 8'hFF};
      dq_in = (!ce_n && !oe_n && we_n) ? val : ~last;
      if (!ce_n && !oe_n && we_n) last = val;
   end
endmodule
`default_nettype wire

// file: verification/flash_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module flash_host_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        req_valid = 1'b0;
   logic [3:0]  req_op = 4'h0;
   logic [17:0] req_addr = 18'h0_0000;
   logic [15:0] req_data = 16'h0000;
   logic        byte_mode = 1'b0;
   logic        temp_unprotect = 1'b0;
   int          n_fail = 0;
   int          tests_run = 0;
   wire         req_ready, done, verify_fail, dq_oe_n, ce_n, oe_n, we_n, a9hv, oehv, cehv, rphv, byte_n;
   wire  [15:0] rd_data, dq_out, dq_in;
   wire  [17:0] addr;

   // short protect and unprotect counts keep the run brief
   always #2.5 clk = ~clk;
   flash_host #(.protect_cycles(20), .unprotect_cycles(50)) u_dut (.clk, .nrst, .req_valid, .req_ready, .req_op,
      .req_addr, .req_data, .byte_mode, .temp_unprotect, .done, .rd_data, .verify_fail, .addr, .dq_out, .dq_in,
      .dq_oe_n, .ce_n, .oe_n, .we_n, .a9_high_volt(a9hv), .oe_high_volt(oehv), .ce_high_volt(cehv),
      .reset_unprotect_pin_high_volt(rphv), .byte_n);
   flash_dev_model #(.prot_min_ns(100)) u_dev (.addr, .dq_out, .dq_in, .ce_n, .oe_n, .we_n, .a9_hv(a9hv),
      .oe_hv(oehv), .ce_hv(cehv), .rp_hv(rphv), .byte_n);

   task automatic conclude;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one request, held until taken, then a bounded wait for done
   task automatic op(input logic [3:0] o, input logic [17:0] a, input logic [15:0] d);
      int i;
      int j;
      req_op <= o;
      req_addr <= a;
      req_data <= d;
      req_valid <= 1'b1;
      i = 0;
      @(posedge clk);
      while (req_ready !== 1'b1 && i < 100)
      begin
         i = i + 1;
         @(posedge clk);
      end
      req_valid <= 1'b0;
      j = 0;
      @(posedge clk);
      while (done !== 1'b1 && j < 5000)
      begin
         j = j + 1;
         @(posedge clk);
      end
      if (i >= 100 || j >= 5000)
      begin
         n_fail++;
         conclude();
      end
   endtask

   task automatic t_program;
      op(flash_host_pkg::op_reset, 18'h0_0000, 16'h0000);
      op(flash_host_pkg::op_program, 18'h0_1005, 16'h003C);
      op(flash_host_pkg::op_read, 18'h0_1005, 16'h0000);
      `CHK(rd_data, 16'h003C)
      $display("program done");
   endtask

   task automatic t_protect;
      op(flash_host_pkg::op_protect, 18'h0_1000, 16'h0000);
      op(flash_host_pkg::op_prot_ver, 18'h0_1000, 16'h0000);
      `CHK(rd_data, 16'h0001)
      `CHK(verify_fail, 1'b0)
      op(flash_host_pkg::op_prot_ver, 18'h0_2000, 16'h0000);
      `CHK(verify_fail, 1'b1)
      op(flash_host_pkg::op_sig_read, 18'h0_1002, 16'h0000);
      `CHK(rd_data, 16'h0001)
      op(flash_host_pkg::op_sig_read, 18'h0_2002, 16'h0000);
      `CHK(rd_data, 16'h0000)
      op(flash_host_pkg::op_program, 18'h0_1005, 16'h0000);
      op(flash_host_pkg::op_read, 18'h0_1005, 16'h0000);
      `CHK(rd_data, 16'h003C)
      $display("protect done");
   endtask

   task automatic t_temp;
      temp_unprotect <= 1'b1;
      op(flash_host_pkg::op_program, 18'h0_1005, 16'h000C);
      op(flash_host_pkg::op_read, 18'h0_1005, 16'h0000);
      `CHK(rd_data, 16'h000C)
      temp_unprotect <= 1'b0;
      op(flash_host_pkg::op_program, 18'h0_1005, 16'h0000);
      op(flash_host_pkg::op_read, 18'h0_1005, 16'h0000);
      `CHK(rd_data, 16'h000C)
      $display("temporary unprotect done");
   endtask

   task automatic t_unprotect;
      op(flash_host_pkg::op_unprotect, 18'h0_9000, 16'h0000);
      `CHK(verify_fail, 1'b1)
      op(flash_host_pkg::op_prot_ver, 18'h0_1000, 16'h0000);
      `CHK(rd_data, 16'h0001)
      for (int b = 0; b < 64; b++)
         op(flash_host_pkg::op_protect, {b[5:0], 12'h000}, 16'h0000);
      op(flash_host_pkg::op_unprotect, 18'h0_9000, 16'h0000);
      op(flash_host_pkg::op_unp_ver, 18'h0_1000, 16'h0000);
      `CHK(rd_data, 16'h0000)
      op(flash_host_pkg::op_unp_ver, 18'h3_F000, 16'h0000);
      `CHK(rd_data, 16'h0000)
      `CHK(verify_fail, 1'b0)
      $display("unprotect done");
   endtask

   task automatic t_erase;
      op(flash_host_pkg::op_blk_erase, 18'h0_1000, 16'h0000);
      op(flash_host_pkg::op_read, 18'h0_1005, 16'h0000);
      `CHK(rd_data, 16'h00FF)
      byte_mode <= 1'b1;
      op(flash_host_pkg::op_program, 18'h0_2003, 16'h005A);
      op(flash_host_pkg::op_read, 18'h0_2003, 16'h0000);
      `CHK(rd_data, 16'h005A)
      byte_mode <= 1'b0;
      op(flash_host_pkg::op_suspend, 18'h0_2000, 16'h0000);
      op(flash_host_pkg::op_resume, 18'h0_2000, 16'h0000);
      op(flash_host_pkg::op_read, 18'h0_2003, 16'h0000);
      `CHK(rd_data, 16'h005A)
      op(flash_host_pkg::op_chip_ers, 18'h0_0000, 16'h0000);
      op(flash_host_pkg::op_read, 18'h0_2003, 16'h0000);
      `CHK(rd_data, 16'h00FF)
      $display("erase done");
   endtask

   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_program();
      t_protect();
      t_temp();
      t_unprotect();
      t_erase();
      conclude();
   end
endmodule
`default_nettype wire
